// >>> core/i2c_bus_event_raw_status.sv
// raw bus-condition flags of an i2c controller with a wishbone register slave
//
// Behaviour
// [R1] repeated start flag when addressed as slave
// [R2] no repeated start flag before address field
// [R3] general call flag only on acked call
// [R4] general call flag held until disable or clear-read
// [R5] bytes after general call go to receive buffer
// [R6] start flag on any start or repeated start
// [R7] stop flag on stop, role qualified
// [R8] slave, qualify bit set: stop only if addressed
// [R9] qualify bit set: no stop after general call
// [R10] slave, qualify bit clear: stop always flagged
// [R11] master, qualify bit set: stop only if active
// [R12] master, qualify bit clear: stop always flagged
// [R13] raw flags at 0x34, reset to zero
// [R14] hold flag, reserved bits zero; writes ignored
module i2c_bus_event_raw_status
    import i2c_event_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bus engine events, one-cycle pulses
    input wire logic startSeen,
    input wire logic restartSeen,
    input wire logic stopSeen,
    input wire logic ownAddrAck,
    input wire logic genCallAck,
    // bus engine levels
    input wire logic masterRole,
    input wire logic masterActive,
    // received bytes from the engine
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    // towards the receive buffer and the engine
    output logic rxPush,
    output logic [7:0] rxPushData,
    output logic busEnable,
    // interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [3:0] flags;
        logic [3:0] mask;
        logic enable;
        logic stopIfAddr;
        logic stopIfMact;
        addr_state_e addrState;
        logic ack;
        logic [31:0] rdata;
        logic push;
        logic [7:0] pushData;
        logic irq;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] flagWord(input logic [3:0] f);
        logic [31:0] w;
        w = RDATA_RST;
        w[FLAG_MSB:FLAG_LSB] = f;
        return w;
    endfunction

    logic busReq, busWr, busRd, gcClrRead, intWrite, stopQualified, slaveRole;
    logic [31:0] wrWord;
    logic [3:0] setFlags, clrFlags;

    assign busReq = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign busWr = busReq & wb_we_i;
    assign busRd = busReq & ~wb_we_i;
    assign slaveRole = ~masterRole;
    assign gcClrRead = busRd & (wb_adr_i == GCCLR_OFS);
    assign intWrite = busWr & (wb_adr_i == INTSTAT_OFS);
    assign wrWord = byteMerge(RDATA_RST, wb_dat_i, wb_sel_i);

    // ----------------------------------------------------------------
    // event qualification
    // ----------------------------------------------------------------
    always_comb
    begin
        stopQualified = 1'b1; // [R10] [R12]
        if (slaveRole && s_r.stopIfAddr)
        begin
            // a general call leaves addrState at ADDR_GCALL, so it never qualifies
            stopQualified = (s_r.addrState == ADDR_OWN); // [R8] [R9]
        end
        else if (masterRole && s_r.stopIfMact)
        begin
            stopQualified = masterActive; // [R11]
        end

        setFlags = 4'h0;
        if (s_r.enable)
        begin
            setFlags[F_STOP] = stopSeen & stopQualified; // [R7]
            setFlags[F_START] = startSeen | restartSeen; // [R6]
            setFlags[F_GCALL] = genCallAck & slaveRole; // [R3]
            // addrState is still NONE while a repeated start precedes the address
            setFlags[F_RESTART] = restartSeen & slaveRole
                                  & (s_r.addrState == ADDR_OWN); // [R1] [R2]
        end

        clrFlags = 4'h0;
        if (intWrite)
        begin
            clrFlags = wrWord[FLAG_MSB:FLAG_LSB];
        end
        // the status write cannot drop general call: only disable or the clear-read do
        clrFlags[F_GCALL] = gcClrRead | ~s_r.enable; // [R4]
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = busReq;
        s_nxt.push = 1'b0;

        // set wins over a clear in the same cycle
        s_nxt.flags = (s_r.flags & ~clrFlags) | setFlags;

        // addressing of the running transfer
        case (s_r.addrState)
            ADDR_NONE:
            begin
                if (ownAddrAck)
                begin
                    s_nxt.addrState = ADDR_OWN;
                end
                else if (genCallAck)
                begin
                    s_nxt.addrState = ADDR_GCALL;
                end
            end
            ADDR_OWN, ADDR_GCALL:
            begin
                // a repeated start keeps the slave addressed until the next stop or start
                if (stopSeen || startSeen)
                begin
                    s_nxt.addrState = ADDR_NONE;
                end
                else if (ownAddrAck)
                begin
                    s_nxt.addrState = ADDR_OWN;
                end
            end
            default:
            begin
                s_nxt.addrState = ADDR_NONE;
            end
        endcase
        if (!s_r.enable || masterRole)
        begin
            s_nxt.addrState = ADDR_NONE;
        end

        // received data of an accepted transfer
        if (rxByteValid && s_r.enable && (s_r.addrState != ADDR_NONE))
        begin
            s_nxt.push = 1'b1; // [R5]
            s_nxt.pushData = rxByte;
        end

        // register writes
        if (busWr)
        begin
            case (wb_adr_i)
                CTRL_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_nxt.enable = wb_dat_i[ENABLE_BIT];
                        s_nxt.stopIfAddr = wb_dat_i[STOP_ADDR_BIT];
                    end
                    if (wb_sel_i[1])
                    begin
                        s_nxt.stopIfMact = wb_dat_i[STOP_MACT_BIT];
                    end
                end
                MASK_OFS:
                begin
                    if (wb_sel_i[1])
                    begin
                        s_nxt.mask = wb_dat_i[FLAG_MSB:FLAG_LSB];
                    end
                end
                default:
                begin
                    // raw flags and unmapped words take no write
                    s_nxt.mask = s_r.mask; // [R14]
                end
            endcase
        end

        // register reads
        s_nxt.rdata = RDATA_RST;
        if (busRd)
        begin
            case (wb_adr_i)
                CTRL_OFS:
                begin
                    s_nxt.rdata[ENABLE_BIT] = s_r.enable;
                    s_nxt.rdata[STOP_ADDR_BIT] = s_r.stopIfAddr;
                    s_nxt.rdata[STOP_MACT_BIT] = s_r.stopIfMact;
                end
                INTSTAT_OFS:
                begin
                    s_nxt.rdata = flagWord(s_r.flags & s_r.mask);
                end
                MASK_OFS:
                begin
                    s_nxt.rdata = flagWord(s_r.mask);
                end
                RAW_OFS:
                begin
                    // hold flag and bits 31..14 stay zero
                    s_nxt.rdata = flagWord(s_r.flags); // [R13] [R14]
                end
                GCCLR_OFS:
                begin
                    s_nxt.rdata[0] = s_r.flags[F_GCALL];
                end
                default:
                begin
                    s_nxt.rdata = RDATA_RST;
                end
            endcase
        end

        s_nxt.irq = |(s_nxt.flags & s_nxt.mask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_r.flags <= FLAGS_RST; // [R13]
            s_r.mask <= MASK_RST;
            s_r.enable <= CTRL_BIT_RST;
            s_r.stopIfAddr <= CTRL_BIT_RST;
            s_r.stopIfMact <= CTRL_BIT_RST;
            s_r.addrState <= ADDR_NONE;
            s_r.ack <= 1'b0;
            s_r.rdata <= RDATA_RST;
            s_r.push <= 1'b0;
            s_r.pushData <= BYTE_RST;
            s_r.irq <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.rdata;
    assign wb_ack_o = s_r.ack;
    assign rxPush = s_r.push;
    assign rxPushData = s_r.pushData;
    assign busEnable = s_r.enable;
    assign irq = s_r.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    logic ownNow, gcNow, rawRead, gcKill;
    assign ownNow = (s_r.addrState == ADDR_OWN);
    assign gcNow = (s_r.addrState == ADDR_GCALL);
    assign rawRead = busRd & (wb_adr_i == RAW_OFS);
    assign gcKill = gcClrRead | ~s_r.enable;

    chk_restart_addressed: assert property ( // [R1] [R2]
        $rose(s_r.flags[F_RESTART]) |-> $past(restartSeen) && $past(ownNow)
                                        && $past(slaveRole))
        else $error("repeated start flag raised while not addressed");

    chk_gcall_source: assert property ( // [R3]
        $rose(s_r.flags[F_GCALL]) |-> $past(genCallAck) && $past(s_r.enable))
        else $error("general call flag raised without an acked call");

    chk_gcall_hold: assert property ( // [R4]
        $fell(s_r.flags[F_GCALL]) |-> $past(gcKill))
        else $error("general call flag dropped without a clear");

    chk_gcall_data: assert property ( // [R5]
        rxByteValid && gcNow && s_r.enable |=> rxPush && (rxPushData == $past(rxByte)))
        else $error("byte after general call not pushed");

    chk_start_flag: assert property ( // [R6]
        (startSeen || restartSeen) && s_r.enable |=> s_r.flags[F_START])
        else $error("start flag missed");

    chk_stop_slave: assert property ( // [R8] [R9]
        $rose(s_r.flags[F_STOP]) && $past(slaveRole) && $past(s_r.stopIfAddr)
        |-> $past(ownNow))
        else $error("stop flag raised for an unaddressed slave");

    chk_stop_master: assert property ( // [R11]
        $rose(s_r.flags[F_STOP]) && $past(masterRole) && $past(s_r.stopIfMact)
        |-> $past(masterActive))
        else $error("stop flag raised with master idle");

    chk_stop_always: assert property ( // [R7] [R10] [R12]
        stopSeen && s_r.enable && ((slaveRole && !s_r.stopIfAddr)
        || (masterRole && !s_r.stopIfMact)) |=> s_r.flags[F_STOP])
        else $error("unqualified stop not flagged");

    chk_raw_read: assert property ( // [R13] [R14]
        rawRead |=> wb_ack_o && (wb_dat_o[31:HOLD_BIT] == '0)
                    && (wb_dat_o[FLAG_MSB:FLAG_LSB] == $past(s_r.flags)))
        else $error("raw flag word read back wrong");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_irq_level: assert property (
        irq == |(s_r.flags & s_r.mask))
        else $error("interrupt level disagrees with flags");

    cov_restart: cover property (restartSeen && ownNow ##1 s_r.flags[F_RESTART]);
    cov_gcall_clear: cover property (s_r.flags[F_GCALL] ##1 gcClrRead ##1 !s_r.flags[F_GCALL]);
    cov_stop_masked: cover property (stopSeen && slaveRole && s_r.stopIfAddr && gcNow);
    cov_irq: cover property ($rose(irq));

endmodule

// >>> core/i2c_event_pkg.sv
// constants and types shared by the i2c bus event status block
package i2c_event_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] INTSTAT_OFS = 8'h2C;
    localparam logic [7:0] MASK_OFS = 8'h30;
    localparam logic [7:0] RAW_OFS = 8'h34;
    localparam logic [7:0] GCCLR_OFS = 8'h68;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int STOP_ADDR_BIT = 7;
    localparam int STOP_MACT_BIT = 10;
    localparam int HOLD_BIT = 13;
    localparam int FLAG_LSB = 9;
    localparam int FLAG_MSB = 12;
    // index inside the four stored flags (bit 9 upward)
    localparam int F_STOP = 0;
    localparam int F_START = 1;
    localparam int F_GCALL = 2;
    localparam int F_RESTART = 3;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic CTRL_BIT_RST = 1'b0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ----------------------------------------------------------------
    // how the device was addressed in the current transfer
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ADDR_NONE = 2'b00,
        ADDR_OWN = 2'b01,
        ADDR_GCALL = 2'b10
    } addr_state_e;

endpackage

// >>> testbench/i2c_engine_model.sv
// bus engine stand-in: plays conditions and addressing seen on the i2c bus
module i2c_engine_model
(
    // clock
    input wire logic clk_sys,
    // engine events
    output logic startSeen,
    output logic restartSeen,
    output logic stopSeen,
    output logic ownAddrAck,
    output logic genCallAck,
    output logic rxByteValid,
    output logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {startSeen, restartSeen, stopSeen, ownAddrAck, genCallAck, rxByteValid} = 6'h00;
        rxByte = 8'h00;
    end
    // ----------------------------------------------------------------
    // one-cycle event pulse
    // ----------------------------------------------------------------
    // byte lane shows the inverse once invalid, so no stale value passes for data
    task pulse(input logic [5:0] ev, input logic [7:0] b);
        @(posedge clk_sys);
        {startSeen, restartSeen, stopSeen, ownAddrAck, genCallAck, rxByteValid} <= ev;
        rxByte <= b;
        @(posedge clk_sys);
        {startSeen, restartSeen, stopSeen, ownAddrAck, genCallAck, rxByteValid} <= 6'h00;
        rxByte <= ~b;
    endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench of the raw bus event flags
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_event_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wbCyc, wbStb, wbWe, wbAck, masterRole, masterActive;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    logic startSeen, restartSeen, stopSeen, ownAddrAck, genCallAck, rxByteValid;
    logic [7:0] rxByte, rxPushData;
    logic rxPush, busEnable, irq;
    int failures = 0;
    int check_count = 0;
    always #20 clk_sys = ~clk_sys;
    i2c_bus_event_raw_status i2c_bus_event_raw_status_inst (.clk_sys(clk_sys), .rstn(rstn),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .startSeen(startSeen), .restartSeen(restartSeen), .stopSeen(stopSeen),
        .ownAddrAck(ownAddrAck), .genCallAck(genCallAck), .masterRole(masterRole),
        .masterActive(masterActive), .rxByteValid(rxByteValid), .rxByte(rxByte),
        .rxPush(rxPush), .rxPushData(rxPushData), .busEnable(busEnable), .irq(irq));
    i2c_engine_model i2c_engine_model_inst (.clk_sys(clk_sys), .startSeen(startSeen),
        .restartSeen(restartSeen), .stopSeen(stopSeen), .ownAddrAck(ownAddrAck),
        .genCallAck(genCallAck), .rxByteValid(rxByteValid), .rxByte(rxByte));
    // ----------------------------------------------------------------
    // wishbone classic cycles
    // ----------------------------------------------------------------
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= 4'hF;
        // no fixed latency assumed: the watchdog ends a wait that never sees ack
        do
        begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic chkRaw(input string nm, input logic [31:0] ex);
        logic [31:0] q;
        wb(1'b0, RAW_OFS, 32'h0, q);
        `CHK(nm, ex, q)
    endtask
    // clears every flag; the clear-read also unsticks the general call flag
    task automatic clearAll;
        logic [31:0] q;
        wr(INTSTAT_OFS, 32'h0000_1E00);
        wb(1'b0, GCCLR_OFS, 32'h0, q);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        `CHK("busEnable", 1'b0, busEnable)
        chkRaw("raw reset", 32'h0);
        i2c_engine_model_inst.pulse(6'h28, 8'h00);
        chkRaw("raw disabled", 32'h0);
        wr(RAW_OFS, 32'hFFFF_FFFF);
        chkRaw("raw written", 32'h0);
        wb(1'b0, 8'h7C, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        wr(CTRL_OFS, 32'h1);
        `CHK("busEnable set", 1'b1, busEnable)
    endtask
    task automatic t_start;
        i2c_engine_model_inst.pulse(6'h20, 8'h00);
        chkRaw("start", 32'h0000_0400);
        clearAll();
        i2c_engine_model_inst.pulse(6'h10, 8'h00);
        chkRaw("restart unaddressed", 32'h0000_0400);
        clearAll();
        i2c_engine_model_inst.pulse(6'h20, 8'h00);
        i2c_engine_model_inst.pulse(6'h04, 8'h00);
        i2c_engine_model_inst.pulse(6'h10, 8'h00);
        chkRaw("restart addressed", 32'h0000_1400);
        clearAll();
    endtask
    task automatic t_gcall;
        logic [31:0] q;
        logic seen;
        i2c_engine_model_inst.pulse(6'h20, 8'h00);
        i2c_engine_model_inst.pulse(6'h01, 8'h3C);
        #1 `CHK("push unaddressed", 1'b0, rxPush)
        i2c_engine_model_inst.pulse(6'h02, 8'h00);
        i2c_engine_model_inst.pulse(6'h01, 8'hA5);
        seen = 1'b0;
        repeat (2)
        begin
            #1 if (rxPush === 1'b1 && rxPushData === 8'hA5) seen = 1'b1;
            @(posedge clk_sys);
        end
        `CHK("push gcall", 1'b1, seen)
        chkRaw("gcall", 32'h0000_0C00);
        wr(INTSTAT_OFS, 32'h0000_0800);
        chkRaw("gcall after w1c", 32'h0000_0C00);
        wb(1'b0, GCCLR_OFS, 32'h0, q);
        `CHK("gcall clear read", 32'h1, q)
        chkRaw("gcall cleared", 32'h0000_0400);
        clearAll();
        i2c_engine_model_inst.pulse(6'h02, 8'h00);
        wr(CTRL_OFS, 32'h0);
        chkRaw("gcall disabled", 32'h0);
        wr(CTRL_OFS, 32'h1);
    endtask
    task automatic t_stop_slave;
        logic [5:0] ev [4] = '{6'h00, 6'h00, 6'h04, 6'h02};
        logic [31:0] ex [4] = '{32'h600, 32'h400, 32'h600, 32'hC00};
        for (int i = 0; i < 4; i++)
        begin
            wr(CTRL_OFS, (i > 0) ? 32'h81 : 32'h01);
            i2c_engine_model_inst.pulse(6'h20, 8'h00);
            if (ev[i] !== 6'h00) i2c_engine_model_inst.pulse(ev[i], 8'h00);
            i2c_engine_model_inst.pulse(6'h08, 8'h00);
            chkRaw("slave stop", ex[i]);
            clearAll();
        end
    endtask
    task automatic t_stop_master;
        logic [31:0] ctl [3] = '{32'h401, 32'h401, 32'h001};
        logic act [3] = '{1'b0, 1'b1, 1'b0};
        logic [31:0] ex [3] = '{32'h400, 32'h600, 32'h600};
        for (int i = 0; i < 3; i++)
        begin
            wr(CTRL_OFS, ctl[i]);
            @(posedge clk_sys);
            masterRole <= 1'b1;
            masterActive <= act[i];
            i2c_engine_model_inst.pulse(6'h20, 8'h00);
            i2c_engine_model_inst.pulse(6'h08, 8'h00);
            chkRaw("master stop", ex[i]);
            clearAll();
        end
        @(posedge clk_sys);
        masterRole <= 1'b0;
        masterActive <= 1'b0;
    endtask
    task automatic t_irq;
        logic [31:0] q;
        wr(MASK_OFS, 32'h200);
        i2c_engine_model_inst.pulse(6'h08, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("irq raised", 1'b1, irq)
        wb(1'b0, INTSTAT_OFS, 32'h0, q);
        `CHK("int status", 32'h200, q)
        wr(INTSTAT_OFS, 32'h200);
        #1 `CHK("irq cleared", 1'b0, irq)
        wr(MASK_OFS, 32'h0);
        i2c_engine_model_inst.pulse(6'h08, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("irq masked", 1'b0, irq)
        chkRaw("raw masked stop", 32'h200);
    endtask
    // ----------------------------------------------------------------
    // verdict and run control
    // ----------------------------------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // the whole sequence needs a few hundred cycles; this leaves a wide margin
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        finish_test();
    end
    initial
    begin
        {wbCyc, wbStb, wbWe, masterRole, masterActive} = 5'h00;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0000_0000;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_start();
        t_gcall();
        t_stop_slave();
        t_stop_master();
        t_irq();
        finish_test();
    end
endmodule
